// File: rtl/phy_wake_regs_pkg.sv
// Constants shared by the wake, event and clock output register bank.
package phy_wake_regs_pkg;

  // Management port geometry.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int WAKE_WORDS = 3;

  // Page select register and its page codes.
  localparam logic [4:0]  OFF_PAGE_SELECT = 5'h1f;
  localparam logic [15:0] PAGE_MAIN       = 16'h0000;
  localparam logic [15:0] PAGE_EXTENDED   = 16'h0001;
  localparam logic [15:0] PAGE_GENERAL    = 16'h0010;

  // Extended page offsets.
  localparam logic [4:0] OFF_WAKE_ADDR_LOW   = 5'h15;
  localparam logic [4:0] OFF_WAKE_ADDR_MID   = 5'h16;
  localparam logic [4:0] OFF_WAKE_ADDR_HIGH  = 5'h17;
  localparam logic [4:0] OFF_WAKE_PASS_LOW   = 5'h18;
  localparam logic [4:0] OFF_WAKE_PASS_MID   = 5'h19;
  localparam logic [4:0] OFF_WAKE_PASS_HIGH  = 5'h1a;
  localparam logic [4:0] OFF_WAKE_MAC_CTRL   = 5'h1b;
  localparam logic [4:0] OFF_EVENT_MASK      = 5'h1c;
  localparam logic [4:0] OFF_EVENT_STATUS    = 5'h1d;

  // General purpose page offsets.
  localparam logic [4:0] OFF_CLOCK_OUTPUT = 5'h0d;

  // Wake and MAC interface control fields.
  localparam int WCTL_SECURE_EN = 15;
  localparam int WCTL_PASS_LEN  = 14;
  localparam int WCTL_REP_HI    = 11;
  localparam int WCTL_REP_LO    = 8;
  localparam int WCTL_EDGE_HI   = 7;
  localparam int WCTL_EDGE_LO   = 5;
  localparam int WCTL_RMII_CLK  = 4;
  localparam int WCTL_CMOS_DRV  = 0;
  localparam logic [15:0] WCTL_RESET = 16'h0ff0;
  localparam logic [15:0] WCTL_WMASK = 16'hcff1;

  // Extended event bit positions, shared by mask and status.
  localparam int EVT_RX_FIFO    = 13;
  localparam int EVT_TX_FIFO    = 12;
  localparam int EVT_LINK_FAIL  = 3;
  localparam int EVT_RX_QUIET   = 2;
  localparam int EVT_RX_SLEEP   = 1;
  localparam int EVT_WAKE_ERR   = 0;
  localparam logic [15:0] EVT_WMASK = 16'h300f;
  localparam logic [15:0] EVT_RESET = 16'h0000;

  // Clock output control fields.
  localparam int CLKO_EN      = 15;
  localparam int CLKO_FREQ_HI = 14;
  localparam int CLKO_FREQ_LO = 13;
  localparam logic [15:0] CLKO_RESET = 16'h0000;
  localparam logic [15:0] CLKO_WMASK = 16'he000;

  // Clock output frequency codes.
  localparam logic [1:0] FREQ_25MHZ  = 2'h0;
  localparam logic [1:0] FREQ_50MHZ  = 2'h1;
  localparam logic [1:0] FREQ_125MHZ = 2'h2;

  localparam logic [15:0] WORD_ZERO = 16'h0000;

endpackage

// File: rtl/phy_wake_irq_reference_clock_output_regs.sv
// Paged management register bank for wake, extended events and clock output.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

module phy_wake_irq_reference_clock_output_regs (
  input  wire logic        core_clk,                 // System clock, 50 MHz.
  input  wire logic        reset_n,                  // Power-on reset, clears everything but the control word, which loads 0ff0.
  input  wire logic        hard_reset,               // Hardware reset pulse.
  input  wire logic        soft_reset,               // Software reset pulse.
  input  wire logic [4:0]  reg_addr,                 // Register address.
  input  wire logic [15:0] reg_wdata,                // Write data.
  input  wire logic        reg_wr,                   // Write strobe.
  input  wire logic        reg_rd,                   // Read strobe.
  output logic      [15:0] reg_rdata,                // Read data, cycle after strobe.
  input  wire logic        rx_fifo_event,            // Receive FIFO over/underflow pulse.
  input  wire logic        tx_fifo_event,            // Transmit FIFO over/underflow pulse.
  input  wire logic        eee_link_fail_event,      // EEE link fail pulse.
  input  wire logic        receive_quiet_timer_event, // Receive quiet timer pulse.
  input  wire logic        receive_sleep_timer_event, // Wait quiet or sleep timer pulse.
  input  wire logic        eee_wake_error_event,     // EEE wake error pulse.
  output logic [47:0]      wake_station_address,     // Magic packet station address.
  output logic [47:0]      wake_password,            // Magic packet password.
  output logic             wake_password_enable,     // Password checking enabled.
  output logic             wake_password_short,      // High selects four-byte password.
  output logic [3:0]       wake_repeat_code,         // Repetitions minus one.
  output logic [2:0]       mac_pad_edge_rate,        // Pad edge rate, 0 slowest.
  output logic             rmii_clock_output_enable, // RMII reference clock out enable.
  output logic             management_interrupt_cmos, // CMOS drive of interrupt pin.
  output logic             management_interrupt_pin, // Interrupt, active high.
  output logic             reference_clock_output_enable, // Clock output pin enable.
  output logic [1:0]       reference_clock_output_freq    // Clock output frequency code.
);

  // Decode of one register address on one page, used for every register but the page select, which decodes on every page.
  function automatic logic reg_hit(input logic [15:0] page,
                                   input logic [4:0]  addr,
                                   input logic [15:0] want_page,
                                   input logic [4:0]  off);
    reg_hit = (page == want_page) && (addr == off);
  endfunction

  // Merge of write data into a register under a writable-bit mask.
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wdata,
                                        input logic [15:0] wmask);
    merge = (old & ~wmask) | (wdata & wmask);
  endfunction

  logic [15:0] page_r;
  logic [15:0] page_nxt;
  logic [15:0] wctl_r;
  logic [15:0] wctl_nxt;
  logic [15:0] mask_r;
  logic [15:0] mask_nxt;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] clko_r;
  logic [15:0] clko_nxt;
  logic [15:0] rdata_nxt;
  logic        irq_nxt;
  logic [15:0] addr_word_r [phy_wake_regs_pkg::WAKE_WORDS];
  logic [15:0] pass_word_r [phy_wake_regs_pkg::WAKE_WORDS];
  logic [15:0] addr_rd     [phy_wake_regs_pkg::WAKE_WORDS];
  logic [15:0] pass_rd     [phy_wake_regs_pkg::WAKE_WORDS];

  // Reset classes: ordinary bits clear on any reset, sticky bits only on a
  // hardware reset, general purpose bits only at power-on.
  wire clr_ordinary = soft_reset | hard_reset;
  wire clr_sticky   = hard_reset;

  // Register decodes.
  wire page_hit = (reg_addr == phy_wake_regs_pkg::OFF_PAGE_SELECT);
  wire wctl_hit = reg_hit(page_r, reg_addr, phy_wake_regs_pkg::PAGE_EXTENDED,
                          phy_wake_regs_pkg::OFF_WAKE_MAC_CTRL);
  wire mask_hit = reg_hit(page_r, reg_addr, phy_wake_regs_pkg::PAGE_EXTENDED,
                          phy_wake_regs_pkg::OFF_EVENT_MASK);
  wire stat_hit = reg_hit(page_r, reg_addr, phy_wake_regs_pkg::PAGE_EXTENDED,
                          phy_wake_regs_pkg::OFF_EVENT_STATUS);
  wire clko_hit = reg_hit(page_r, reg_addr, phy_wake_regs_pkg::PAGE_GENERAL,
                          phy_wake_regs_pkg::OFF_CLOCK_OUTPUT);

  // Page select takes any written value; only the known codes map registers.
  assign page_nxt = (reg_wr && page_hit) ? reg_wdata : page_r;

  // Wake and MAC interface control with its reserved bits held at zero.
  assign wctl_nxt = (reg_wr && wctl_hit) ?
                    merge(wctl_r, reg_wdata, phy_wake_regs_pkg::WCTL_WMASK) : wctl_r;

  // Event mask: only the six defined enables are writable.
  assign mask_nxt = (reg_wr && mask_hit) ?
                    merge(mask_r, reg_wdata, phy_wake_regs_pkg::EVT_WMASK) : mask_r;

  // Clock output control in the general purpose page.
  assign clko_nxt = (reg_wr && clko_hit) ?
                    merge(clko_r, reg_wdata, phy_wake_regs_pkg::CLKO_WMASK) : clko_r;

  // Incoming events placed at their status positions.
  logic [15:0] event_vec;
  always_comb begin
    event_vec = phy_wake_regs_pkg::WORD_ZERO;
    event_vec[phy_wake_regs_pkg::EVT_RX_FIFO]   = rx_fifo_event;
    event_vec[phy_wake_regs_pkg::EVT_TX_FIFO]   = tx_fifo_event;
    event_vec[phy_wake_regs_pkg::EVT_LINK_FAIL] = eee_link_fail_event;
    event_vec[phy_wake_regs_pkg::EVT_RX_QUIET]  = receive_quiet_timer_event;
    event_vec[phy_wake_regs_pkg::EVT_RX_SLEEP]  = receive_sleep_timer_event;
    event_vec[phy_wake_regs_pkg::EVT_WAKE_ERR]  = eee_wake_error_event;
  end

  // A read of the status word clears it; an event in the same cycle survives
  // so that nothing is lost between the read and the clear.
  wire stat_rd = reg_rd && stat_hit;
  assign status_nxt = ((stat_rd ? phy_wake_regs_pkg::WORD_ZERO : status_r) | event_vec)
                      & phy_wake_regs_pkg::EVT_WMASK;

  // Interrupt follows the next status so it drops in step with the clear.
  assign irq_nxt = |(status_nxt & mask_nxt);

  // Wake address and password words, three of each.
  genvar i;
  generate
    for (i = 0; i < phy_wake_regs_pkg::WAKE_WORDS; i++) begin : g_wake
      localparam int AOFF = int'(phy_wake_regs_pkg::OFF_WAKE_ADDR_LOW) + i;
      localparam int POFF = int'(phy_wake_regs_pkg::OFF_WAKE_PASS_LOW) + i;
      wire a_hit = reg_hit(page_r, reg_addr, phy_wake_regs_pkg::PAGE_EXTENDED, AOFF[4:0]);
      wire p_hit = reg_hit(page_r, reg_addr, phy_wake_regs_pkg::PAGE_EXTENDED, POFF[4:0]);

      // Sticky storage: survives a software reset.
      always_ff @(posedge core_clk) begin
        if (!reset_n || clr_sticky) begin
          addr_word_r[i] <= phy_wake_regs_pkg::WORD_ZERO;
          pass_word_r[i] <= phy_wake_regs_pkg::WORD_ZERO;
        end else begin
          if (reg_wr && a_hit) begin
            addr_word_r[i] <= reg_wdata;
          end
          if (reg_wr && p_hit) begin
            pass_word_r[i] <= reg_wdata;
          end
        end
      end

      assign addr_rd[i] = a_hit ? addr_word_r[i] : phy_wake_regs_pkg::WORD_ZERO;
      assign pass_rd[i] = p_hit ? pass_word_r[i] : phy_wake_regs_pkg::WORD_ZERO;
    end
  endgenerate

  // Read mux; unmapped addresses and the main page read as zero.
  assign rdata_nxt = (page_hit ? page_r : phy_wake_regs_pkg::WORD_ZERO)
                   | (wctl_hit ? wctl_r : phy_wake_regs_pkg::WORD_ZERO)
                   | (mask_hit ? mask_r : phy_wake_regs_pkg::WORD_ZERO)
                   | (stat_hit ? status_r : phy_wake_regs_pkg::WORD_ZERO)
                   | (clko_hit ? clko_r : phy_wake_regs_pkg::WORD_ZERO)
                   | addr_rd[0] | addr_rd[1] | addr_rd[2]
                   | pass_rd[0] | pass_rd[1] | pass_rd[2];

  // Ordinary state: page select, status, interrupt and read data.
  always_ff @(posedge core_clk) begin
    if (!reset_n || clr_ordinary) begin
      page_r                   <= phy_wake_regs_pkg::PAGE_MAIN;
      status_r                 <= phy_wake_regs_pkg::EVT_RESET;
      management_interrupt_pin <= 1'b0;
      reg_rdata                <= phy_wake_regs_pkg::WORD_ZERO;
    end else begin
      page_r                   <= page_nxt;
      status_r                 <= status_nxt;
      management_interrupt_pin <= irq_nxt;
      reg_rdata                <= reg_rd ? rdata_nxt : phy_wake_regs_pkg::WORD_ZERO;
    end
  end

  // Sticky control words.
  always_ff @(posedge core_clk) begin
    if (!reset_n || clr_sticky) begin
      wctl_r <= phy_wake_regs_pkg::WCTL_RESET;
      mask_r <= phy_wake_regs_pkg::EVT_RESET;
    end else begin
      wctl_r <= wctl_nxt;
      mask_r <= mask_nxt;
    end
  end

  // General purpose space is super-sticky: only power-on clears it, never the
  // hardware or software reset pulses.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      clko_r <= phy_wake_regs_pkg::CLKO_RESET;
    end else begin
      clko_r <= clko_nxt;
    end
  end

  // Output views of stored words; each bit is a flip-flop.
  assign wake_station_address = {addr_word_r[2], addr_word_r[1], addr_word_r[0]};
  assign wake_password        = {pass_word_r[2], pass_word_r[1], pass_word_r[0]};
  assign wake_password_enable = wctl_r[phy_wake_regs_pkg::WCTL_SECURE_EN];
  assign wake_password_short  = wctl_r[phy_wake_regs_pkg::WCTL_PASS_LEN];
  assign wake_repeat_code     =
    wctl_r[phy_wake_regs_pkg::WCTL_REP_HI:phy_wake_regs_pkg::WCTL_REP_LO];
  assign mac_pad_edge_rate    =
    wctl_r[phy_wake_regs_pkg::WCTL_EDGE_HI:phy_wake_regs_pkg::WCTL_EDGE_LO];
  assign rmii_clock_output_enable  = wctl_r[phy_wake_regs_pkg::WCTL_RMII_CLK];
  assign management_interrupt_cmos = wctl_r[phy_wake_regs_pkg::WCTL_CMOS_DRV];
  assign reference_clock_output_enable = clko_r[phy_wake_regs_pkg::CLKO_EN];
  // The reserved code 11 is stored and passed on; the clock generator decides.
  assign reference_clock_output_freq =
    clko_r[phy_wake_regs_pkg::CLKO_FREQ_HI:phy_wake_regs_pkg::CLKO_FREQ_LO];

endmodule

// File: sim/wake_regs_monitor.sv
// Checker for the wake, event and clock output register bank.
`timescale 1ns/1ps
module wake_regs_monitor (
  input wire logic        core_clk,                      // Clock.
  input wire logic        reset_n,                       // Reset, active low.
  input wire logic        hard_reset,                    // Hardware reset.
  input wire logic        soft_reset,                    // Software reset.
  input wire logic [4:0]  reg_addr,                      // Address.
  input wire logic [15:0] reg_wdata,                     // Write data.
  input wire logic        reg_wr,                        // Write strobe.
  input wire logic        reg_rd,                        // Read strobe.
  input wire logic [15:0] reg_rdata,                     // Read data.
  input wire logic        rx_fifo_event,                 // Event.
  input wire logic        tx_fifo_event,                 // Event.
  input wire logic        eee_link_fail_event,           // Event.
  input wire logic        receive_quiet_timer_event,     // Event.
  input wire logic        receive_sleep_timer_event,     // Event.
  input wire logic        eee_wake_error_event,          // Event.
  input wire logic [47:0] wake_station_address,          // Station address.
  input wire logic [47:0] wake_password,                 // Password.
  input wire logic [3:0]  wake_repeat_code,              // Repeat code.
  input wire logic [2:0]  mac_pad_edge_rate,             // Edge rate.
  input wire logic        rmii_clock_output_enable,      // RMII clock enable.
  input wire logic        management_interrupt_pin,      // Interrupt.
  input wire logic        reference_clock_output_enable, // Clock output enable.
  input wire logic [1:0]  reference_clock_output_freq    // Clock output code.
);
  logic [15:0] page_r;
  // Shadow of the page select, since the page itself never leaves the block.
  always_ff @(posedge core_clk) begin
    if (!reset_n || hard_reset || soft_reset) page_r <= 16'h0000;
    else if (reg_wr && reg_addr == 5'h1f) page_r <= reg_wdata;
  end
  wire logic on_ext = (page_r == 16'h0001);
  wire logic on_gp  = (page_r == 16'h0010);
  wire logic any_evt = rx_fifo_event | tx_fifo_event | eee_link_fail_event |
                       receive_quiet_timer_event | receive_sleep_timer_event | eee_wake_error_event;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Clean writes free of any reset in the same cycle, and status reads free of any event.
  sequence s_ext_wr(a); reg_wr && on_ext && !hard_reset && !soft_reset && reg_addr == a; endsequence
  sequence s_gp_wr(a); reg_wr && on_gp && !hard_reset && !soft_reset && reg_addr == a; endsequence
  sequence s_st_rd; reg_rd && on_ext && reg_addr == 5'h1d && !any_evt; endsequence
  property p_addr_mid; s_ext_wr(5'h16) |=> wake_station_address[31:16] == $past(reg_wdata); endproperty
  property p_addr_high; s_ext_wr(5'h17) |=> wake_station_address[47:32] == $past(reg_wdata); endproperty
  property p_addr_low; s_ext_wr(5'h15) |=> wake_station_address[15:0] == $past(reg_wdata); endproperty
  property p_pass_high; s_ext_wr(5'h1a) |=> wake_password[47:32] == $past(reg_wdata); endproperty
  property p_ctrl; s_ext_wr(5'h1b) |=>
    {wake_repeat_code, mac_pad_edge_rate, rmii_clock_output_enable} == $past(reg_wdata[11:4]);
  endproperty
  property p_clko; s_gp_wr(5'h0d) |=>
    {reference_clock_output_enable, reference_clock_output_freq} == $past(reg_wdata[15:13]);
  endproperty
  property p_clko_keep; (hard_reset || soft_reset) && !reg_wr |=>
    $stable({reference_clock_output_enable, reference_clock_output_freq}); endproperty
  property p_hard; hard_reset |=>
    wake_station_address == 48'h0 && wake_repeat_code == 4'hf && rmii_clock_output_enable; endproperty
  property p_soft; soft_reset && !hard_reset && !reg_wr |=>
    $stable(wake_station_address) && $stable(wake_password); endproperty
  property p_irq_rise; $rose(management_interrupt_pin) |-> $past(any_evt) || $past(reg_wr); endproperty
  property p_irq_fall; $fell(management_interrupt_pin) |->
    $past(reg_rd || reg_wr || hard_reset || soft_reset); endproperty
  property p_st_clear; s_st_rd ##1 !any_evt && !reg_wr ##1 s_st_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_addr_mid: assert property (p_addr_mid) else $error("mid address word wrong");
  a_addr_high: assert property (p_addr_high) else $error("high address word wrong");
  a_addr_low: assert property (p_addr_low) else $error("low address word wrong");
  a_pass_high: assert property (p_pass_high) else $error("password word wrong");
  a_ctrl: assert property (p_ctrl) else $error("control fields wrong");
  a_clko: assert property (p_clko) else $error("clock output fields wrong");
  a_clko_keep: assert property (p_clko_keep) else $error("clock output lost");
  a_hard: assert property (p_hard) else $error("sticky not cleared");
  a_soft: assert property (p_soft) else $error("sticky lost");
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped");
  a_st_clear: assert property (p_st_clear) else $error("status not cleared");
endmodule
bind phy_wake_irq_reference_clock_output_regs wake_regs_monitor u_mon (
  .core_clk(core_clk), .reset_n(reset_n), .hard_reset(hard_reset), .soft_reset(soft_reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_fifo_event(rx_fifo_event), .tx_fifo_event(tx_fifo_event),
  .eee_link_fail_event(eee_link_fail_event), .eee_wake_error_event(eee_wake_error_event),
  .receive_quiet_timer_event(receive_quiet_timer_event),
  .receive_sleep_timer_event(receive_sleep_timer_event),
  .wake_station_address(wake_station_address), .wake_password(wake_password),
  .wake_repeat_code(wake_repeat_code), .mac_pad_edge_rate(mac_pad_edge_rate),
  .rmii_clock_output_enable(rmii_clock_output_enable),
  .management_interrupt_pin(management_interrupt_pin),
  .reference_clock_output_enable(reference_clock_output_enable),
  .reference_clock_output_freq(reference_clock_output_freq));

// File: sim/tb_top.sv
// Self-checking bench for the wake, event and clock output register bank.
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, reset_n, hard_reset, soft_reset, reg_wr, reg_rd;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [5:0]  evt;
  logic [47:0] wsa, wpw;
  logic        pw_en, pw_short, rmii_en, irq_cmos, irq, clko_en;
  logic [3:0]  rep;
  logic [2:0]  edge_rate;
  logic [1:0]  clko_freq;
  int          n_fail, total_checks, cycles;
  int          evt_pos [6] = '{13, 12, 3, 2, 1, 0};
  phy_wake_irq_reference_clock_output_regs DUT (
    .core_clk(core_clk), .reset_n(reset_n), .hard_reset(hard_reset), .soft_reset(soft_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_fifo_event(evt[0]), .tx_fifo_event(evt[1]),
    .eee_link_fail_event(evt[2]), .receive_quiet_timer_event(evt[3]),
    .receive_sleep_timer_event(evt[4]), .eee_wake_error_event(evt[5]),
    .wake_station_address(wsa), .wake_password(wpw), .wake_password_enable(pw_en),
    .wake_password_short(pw_short), .wake_repeat_code(rep), .mac_pad_edge_rate(edge_rate),
    .rmii_clock_output_enable(rmii_en), .management_interrupt_cmos(irq_cmos),
    .management_interrupt_pin(irq), .reference_clock_output_enable(clko_en),
    .reference_clock_output_freq(clko_freq));
  // Free-running 50 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Hang guard: the whole run needs well under a thousand cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  // Wide enough for the joined address and password compare, which is 96 bits.
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus tasks end at a falling edge so outputs have settled before any compare.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge core_clk);
    {hard_reset, soft_reset, evt} <= v;
    @(posedge core_clk);
    {hard_reset, soft_reset, evt} <= 8'h00;
    @(negedge core_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {reset_n, hard_reset, soft_reset, reg_wr, reg_rd, reg_addr, reg_wdata, evt} = '0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk({clko_en, clko_freq, rmii_en, edge_rate, rep}, 11'h0ff);
    wr(5'h1f, 16'h0001);
    for (int a = 'h15; a <= 'h1d; a++) rd(5'(a), (a == 'h1b) ? 16'h0ff0 : 16'h0000);
    for (int i = 0; i < 6; i++) wr(5'h15 + 5'(i), 16'h1111 * 16'(i + 1));
    chk({wsa, wpw}, 96'h3333_2222_1111_6666_5555_4444);
    rd(5'h17, 16'h3333);
    $display("test wake words done");
    wr(5'h1b, 16'hffff);
    rd(5'h1b, 16'hcff1);
    chk({pw_en, irq_cmos}, 2'h3);
    wr(5'h1b, 16'h4a00);
    chk({pw_en, pw_short, rep, edge_rate, rmii_en}, 10'b0110100000);
    $display("test control done");
    wr(5'h1c, 16'hffff);
    rd(5'h1c, 16'h300f);
    // Each event in turn: pending, interrupt up, cleared by reading.
    for (int i = 0; i < 6; i++) begin
      pulse(8'(1 << i));
      chk(irq, 1'b1);
      rd(5'h1d, 16'h0001 << evt_pos[i]);
      chk(irq, 1'b0);
      rd(5'h1d, 16'h0000);
    end
    wr(5'h1c, 16'h0000);
    pulse(8'h01);
    chk(irq, 1'b0);
    rd(5'h1d, 16'h2000);
    $display("test events done");
    wr(5'h1f, 16'h0010);
    rd(5'h1b, 16'h0000);
    rd(5'h0d, 16'h0000);
    for (int f = 0; f < 4; f++) begin
      wr(5'h0d, {1'b1, 2'(f), 13'h1fff});
      chk({clko_en, clko_freq}, {1'b1, 2'(f)});
    end
    rd(5'h0d, 16'he000);
    $display("test page done");
    pulse(8'h80);
    chk({clko_en, clko_freq, wsa, rmii_en}, {3'h7, 48'h0, 1'b1});
    wr(5'h1f, 16'h0010);
    rd(5'h0d, 16'he000);
    wr(5'h1f, 16'h0001);
    wr(5'h15, 16'habcd);
    pulse(8'h40);
    chk({clko_en, wsa}, {1'b1, 48'habcd});
    rd(5'h15, 16'h0000);
    wr(5'h1f, 16'h0001);
    rd(5'h15, 16'habcd);
    wr(5'h1f, 16'h0000);
    rd(5'h1f, 16'h0000);
    rd(5'h0d, 16'h0000);
    $display("test resets done");
    complete_run();
  end
endmodule
